// ==== hw/adcseq_consts.vh ====
/*
 constants for the converter acquire/convert sequencer:
 field positions, trigger codes, conversion length.
 assumes inclusion by bare name from hw/adcseq.v.
*/
`ifndef ADCSEQ_CONSTS_VH
`define ADCSEQ_CONSTS_VH

// ==========================================================
// trigger source codes
`define ADCSEQ_TRIG_SW 3'h0
`define ADCSEQ_TRIG_CLK 3'h7

// ==========================================================
// field widths and bit positions
`define ADCSEQ_DONE_BIT 0
`define ADCSEQ_IRQ_BIT 1
`define ADCSEQ_PRE_W 8
`define ADCSEQ_CNT_W 5

// ==========================================================
// conversion length in conversion clock periods
`define ADCSEQ_CONV_TADS 4'hc
`define ADCSEQ_CONV_LAST 4'hb

`endif

// ==== hw/adcseq.v ====
/*
 acquire / convert sequencer for a successive approximation converter.
 assumes software drives the control bits as plain synchronous ports
 (one-cycle write strobes); the analog core takes conv_busy and
 acquiring as its steering levels. one clock, ref_clk.
*/
// Contract
// - done flag, bit 0 of control one, sets when a conversion finishes
// - with auto acquire off, done stays set until software clears it
// - with auto acquire on, done clears as the next acquisition begins; on re-entry the code clears it one cycle later
// - interrupt flag, bit 1 of status one, latches on every completion
// - trigger select 000: clearing acquire control starts conversion
// - software trigger: setting acquire control acquires, clearing converts
// - auto acquire starts acquisition and re-enters it after each conversion
// - in auto acquire hardware sets acquire control at acquisition start
// - any trigger event ends acquisition and starts conversion at once
// - trigger select 111: count acquire_tad_count periods, then convert
// - each conversion lasts twelve conversion clock periods
// - conversion clock period is two times (prescale plus one) clocks
`default_nettype none
`include "adcseq_consts.vh"

module adcseq
(
  input wire ref_clk,
  input wire rst_n,
  input wire clk_en,
  input wire module_on,
  input wire [2:0] trigger_source_select,
  input wire [`ADCSEQ_CNT_W-1:0] acquire_tad_count,
  input wire [`ADCSEQ_PRE_W-1:0] clock_prescale_select,
  input wire auto_acquire,
  input wire acquire_set,
  input wire acquire_clr,
  input wire done_clr,
  input wire irq_flag_clr,
  input wire ext_trigger,
  output reg acquire_control,
  output reg conv_done,
  output reg converter_irq_flag,
  output reg acquiring,
  output reg conv_busy,
  output reg result_commit
);

  // ========================================================
  // state machine
  localparam ST_IDLE = 2'h0;
  localparam ST_ACQ = 2'h1;
  localparam ST_CONV = 2'h2;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [`ADCSEQ_PRE_W:0] pre_cnt_r;
  reg [3:0] bit_cnt_r;
  reg [`ADCSEQ_CNT_W-1:0] acq_cnt_r;
  reg tad_tick;
  reg trig;
  reg acq_start;
  reg conv_end;
  reg tad_run;
  reg acq_first_r;

  // ========================================================
  // conversion clock: one tick every 2*(prescale+1) clocks
  always @*
  begin
    tad_run = (state_r != ST_IDLE);
    tad_tick = tad_run &&
      (pre_cnt_r == {clock_prescale_select, 1'b1});
    conv_end = (state_r == ST_CONV) && tad_tick &&
      (bit_cnt_r == `ADCSEQ_CONV_LAST);
    // any trigger source ends acquisition at once
    case (trigger_source_select)
      `ADCSEQ_TRIG_SW: trig = acquire_clr;
      `ADCSEQ_TRIG_CLK: trig = tad_tick &&
        (acq_cnt_r + 5'h1 >= acquire_tad_count);
      default: trig = ext_trigger;
    endcase
    acq_start = 1'b0;
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (acquire_set || auto_acquire)
        begin
          state_nxt = ST_ACQ;
          acq_start = 1'b1;
        end
      end
      ST_ACQ:
      begin
        if (trig)
          state_nxt = ST_CONV;
      end
      ST_CONV:
      begin
        if (conv_end)
        begin
          // auto mode goes straight back to acquiring
          if (auto_acquire)
          begin
            state_nxt = ST_ACQ;
            acq_start = 1'b1;
          end
          else
            state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // power-off aborts without committing a result
    if (!module_on)
    begin
      state_nxt = ST_IDLE;
      acq_start = 1'b0;
    end
  end

  // ========================================================
  // phase register and steering levels
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      acquiring <= 1'b0;
      conv_busy <= 1'b0;
      acq_first_r <= 1'b0;
    end
    else if (clk_en)
    begin
      state_r <= state_nxt;
      acquiring <= (state_nxt == ST_ACQ);
      conv_busy <= (state_nxt == ST_CONV);
      // auto re-entry shares its edge with the done set
      acq_first_r <= acq_start;
    end
  end

  // ========================================================
  // conversion clock divider
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pre_cnt_r <= 9'h000;
    else if (clk_en)
    begin
      // restart on every phase change for whole periods
      if (!tad_run || tad_tick || state_nxt != state_r || acq_start)
        pre_cnt_r <= 9'h000;
      else
        pre_cnt_r <= pre_cnt_r + 9'h001;
    end
  end

  // ========================================================
  // conversion and acquisition period counters
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt_r <= 4'h0;
      acq_cnt_r <= 5'h00;
    end
    else if (clk_en)
    begin
      if (state_r != ST_CONV)
        bit_cnt_r <= 4'h0;
      else if (tad_tick)
        bit_cnt_r <= bit_cnt_r + 4'h1;
      if (acq_start || state_r != ST_ACQ)
        acq_cnt_r <= 5'h00;
      else if (tad_tick)
        acq_cnt_r <= acq_cnt_r + 5'h01;
    end
  end

  // ========================================================
  // acquire control
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      acquire_control <= 1'b0;
    else if (clk_en)
    begin
      // mirrors the acquire phase
      if (acq_start)
        acquire_control <= 1'b1;
      else if (state_nxt != ST_ACQ)
        acquire_control <= 1'b0;
    end
  end

  // ========================================================
  // completion strobe and flags
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_done <= 1'b0;
      converter_irq_flag <= 1'b0;
      result_commit <= 1'b0;
    end
    else if (clk_en)
    begin
      result_commit <= conv_end && module_on;
      // set wins; on re-entry the clear lands one cycle late
      if (conv_end && module_on)
        conv_done <= 1'b1;
      else if ((acq_start || acq_first_r) && auto_acquire)
        conv_done <= 1'b0;
      else if (done_clr)
        conv_done <= 1'b0;
      if (conv_end && module_on)
        converter_irq_flag <= 1'b1;
      else if (irq_flag_clr)
        converter_irq_flag <= 1'b0;
    end
  end

endmodule // adcseq
`default_nettype wire

// ==== tb/adcseq_monitor.sv ====
/* sequencer port checker; assumes bind into adcseq, one clock. */
`default_nettype none
module adcseq_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] trigger_source_select,
  input wire logic [7:0] clock_prescale_select,
  input wire logic auto_acquire,
  input wire logic acquire_set,
  input wire logic acquire_clr,
  input wire logic done_clr,
  input wire logic irq_flag_clr,
  input wire logic acquire_control,
  input wire logic conv_done,
  input wire logic converter_irq_flag,
  input wire logic acquiring,
  input wire logic conv_busy,
  input wire logic result_commit
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ========
  // phases and flags
  sequence conv_run;
    conv_busy [*8] ##17 result_commit;
  endsequence
  commit_flags_a:
    assert property (result_commit |-> conv_done && converter_irq_flag)
    else $error("flags missing at commit");
  done_hold_a:
    assert property (conv_done && !auto_acquire && !done_clr |=> conv_done)
    else $error("done dropped");
  irq_hold_a:
    assert property (converter_irq_flag && !irq_flag_clr |=> converter_irq_flag)
    else $error("irq dropped");
  auto_clear_a:
    assert property (auto_acquire && $rose(acquiring) |-> acquire_control
      ##1 !conv_done) else $error("auto start wrong");
  sw_trig_a:
    assert property (acquiring && acquire_clr && trigger_source_select == 3'h0
      |=> conv_busy && !acquiring) else $error("no conversion");
  start_acq_a:
    assert property (!acquiring && !conv_busy && acquire_set |=> acquiring &&
      acquire_control) else $error("no acquisition");
  conv_len_a:
    assert property ($rose(conv_busy) && clock_prescale_select == 8'h0 |->
      conv_run) else $error("conversion length");
  commit_pulse_a:
    assert property (result_commit |=> !result_commit && !conv_busy)
    else $error("commit too long");
endmodule // adcseq_monitor
bind adcseq adcseq_monitor u_mon (.*);
`default_nettype wire

// ==== tb/adcseq_trig_model.sv ====
/* other trigger source; assumes the sequencer clock. */
`default_nettype none
module adcseq_trig_model (
  input wire logic clk,
  input wire logic acquiring,
  input wire logic [3:0] hold,
  output var logic trig = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_r = 4'h0;
  // ========
  // fires hold plus one cycles in, so the input has settled
  always @(posedge clk)
  begin
    cnt_r <= acquiring ? cnt_r + 4'h1 : 4'h0;
    trig <= acquiring && cnt_r == hold;
  end
endmodule // adcseq_trig_model
`default_nettype wire

// ==== tb/adcseq_tb_top.sv ====
/* sequencer bench; assumes model and checker compiled alongside. */
`default_nettype none
module adcseq_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0, rst_n = 1'b0, auto_acquire = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [4:0] tads = 5'h1;
  logic [7:0] pre = 8'h0;
  logic [3:0] sw = 4'h0, hold = 4'h3;
  wire trig, ac, dn, irq, acq, busy, cm;
  wire [2:0] st = {busy, acq, cm};
  int seed = 32'he148, failures = 0, n_compared = 0, k;
  adcseq DUT (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
    .module_on(1'b1), .trigger_source_select(sel), .acquire_tad_count(tads),
    .clock_prescale_select(pre), .auto_acquire(auto_acquire),
    .acquire_set(sw[0]), .acquire_clr(sw[1]), .done_clr(sw[2]),
    .irq_flag_clr(sw[3]), .ext_trigger(trig), .acquire_control(ac),
    .conv_done(dn), .converter_irq_flag(irq), .acquiring(acq),
    .conv_busy(busy), .result_commit(cm));
  adcseq_trig_model u_trig (.clk(ref_clk), .acquiring(acq), .hold(hold),
    .trig(trig));
  initial forever #4 ref_clk = ~ref_clk;
  function automatic int tad(input int pv);
    return 2 * (pv + 1);
  endfunction
  task automatic chk(input bit ok);
    n_compared++;
    failures += int'(!ok);
    if (!ok) $display("ERROR %0t: mismatch", $time);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic pulse(input int b);
    @(negedge ref_clk) sw = 4'h1 << b;
    @(negedge ref_clk) sw = 4'h0;
  endtask
  // bounded wait; k counts edges until the chosen output is high
  task automatic waitk(input int b);
    k = 0;
    do @(posedge ref_clk) #1 k++; while (st[b] !== 1'b1 && k < 3000);
    chk(k < 3000);
    if (k >= 3000) tally_and_finish;
  endtask
  initial
  begin
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      pre = 8'(i);
      pulse(0);
      repeat ($random(seed) & 7) @(negedge ref_clk);
      chk(acq === 1'b1 && ac === 1'b1);
      pulse(1);
      waitk(0);
      chk(k == 12 * tad(i) && dn === 1'b1 && irq === 1'b1);
      repeat (5) @(negedge ref_clk);
      chk(dn === 1'b1);
      pulse(2);
      chk(dn === 1'b0 && irq === 1'b1);
      pulse(3);
    end
    sel = 3'h7;
    for (int i = 0; i < 3; i++)
    begin
      pre = 8'($random(seed) & 3);
      tads = 5'(1 + ($random(seed) & 3));
      @(negedge ref_clk) auto_acquire = 1'b1;
      waitk(1);
      waitk(2);
      chk(k == tads * tad(pre));
      waitk(0);
      waitk(1);
      chk(dn === 1'b0 && ac === 1'b1 && irq === 1'b1);
      @(negedge ref_clk) auto_acquire = 1'b0;
      waitk(0);
      pulse(3);
    end
    sel = 3'h2;
    for (int i = 0; i < 2; i++)
    begin
      hold = 4'($random(seed) & 7);
      pulse(0);
      waitk(2);
      chk(k == hold + 2);
      waitk(0);
    end
    @(negedge ref_clk) sel = 3'h0;
    auto_acquire = 1'b1;
    waitk(1);
    for (int i = 0; i < 2; i++)
    begin
      pulse(1);
      waitk(0);
      waitk(1);
      chk(k == 1 && dn === 1'b0 && ac === 1'b1 && irq === 1'b1);
    end
    @(negedge ref_clk) auto_acquire = 1'b0;
    pulse(1);
    waitk(0);
    tally_and_finish;
  end
endmodule // adcseq_tb_top
`default_nettype wire
